// ---- logic/bwd_consts.svh ----
// Constants for the board watchdog timer
`ifndef BWD_CONSTS_SVH
`define BWD_CONSTS_SVH
`define BWD_UNLOCK_KEY    8'h87
`define BWD_REG_LDN       8'h07
`define BWD_REG_ACT       8'h30
`define BWD_REG_UNIT      8'hF3
`define BWD_REG_TMO       8'hF4
`define BWD_WDT_LDN       8'h08
`define BWD_UNIT_SECONDS  8'h00
`define BWD_TMO_OFF       8'h00
`define BWD_RST_BYTE      8'h00
`define BWD_CLK_HZ        20000000
`define BWD_SEC_CYCLES    (`BWD_CLK_HZ * 1)
`define BWD_RST_PULSE     16
`endif

// ---- logic/bwd_pkg.sv ----
// Types for the board watchdog timer
`default_nettype none
package bwd_pkg;
    typedef enum logic [1:0] {
        BWD_LOCKED = 2'b00,
        BWD_HALF   = 2'b01,
        BWD_OPEN   = 2'b11
    } bwd_cfg_state_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       sel_data;
        logic [7:0] wdata;
    } bwd_io_t;
endpackage
`default_nettype wire

// ---- logic/bwd_tick.sv ----
// One-second tick prescaler for the board watchdog timer
`timescale 1ns/1ps
`default_nettype none
`include "bwd_consts.svh"
module bwd_tick #(
    parameter int unsigned DIV = `BWD_SEC_CYCLES
) (
    input  wire logic i_ref_clk,
    input  wire logic i_arst_n,
    input  wire logic i_ce,
    input  wire logic i_clear,
    output logic      o_tick
);
    localparam int unsigned W = $clog2(DIV + 1);
    logic [W-1:0] cnt;
    wire          wrap = (cnt == W'(DIV - 1));
    assign o_tick = i_ce & wrap & ~i_clear;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= '0;
        end else if (i_ce) begin
            if (i_clear || wrap) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/bwd_top.sv ----
// Board watchdog timer behind an index/data configuration port pair
`timescale 1ns/1ps
`default_nettype none
`include "bwd_consts.svh"
module bwd_top
    import bwd_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `BWD_SEC_CYCLES,
    parameter int unsigned RST_CYCLES = `BWD_RST_PULSE
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_ce,
    input  wire bwd_pkg::bwd_io_t i_io,
    input  wire logic          i_refresh,
    output logic [7:0]         o_rdata,
    output logic               o_running,
    output logic               o_sys_rst
);
    import bwd_pkg::*;

    bwd_cfg_state_t cfg_state;
    logic [7:0]     index;
    logic [7:0]     ldn;
    logic [7:0]     activate;
    logic [7:0]     unit;
    logic [7:0]     tmo;
    logic [7:0]     remain;
    logic [7:0]     rst_cnt;
    logic           tick;

    wire idx_wr   = i_io.wr & ~i_io.sel_data;
    wire dat_wr   = i_io.wr & i_io.sel_data;
    wire key_wr   = idx_wr & (i_io.wdata == `BWD_UNLOCK_KEY);
    wire is_open  = (cfg_state == BWD_OPEN);
    wire wdt_sel  = (ldn == `BWD_WDT_LDN);
    wire wr_ldn   = is_open & dat_wr & (index == `BWD_REG_LDN);
    wire wr_act   = is_open & dat_wr & wdt_sel & (index == `BWD_REG_ACT);
    wire wr_unit  = is_open & dat_wr & wdt_sel & (index == `BWD_REG_UNIT);
    wire wr_tmo   = is_open & dat_wr & wdt_sel & (index == `BWD_REG_TMO);
    wire active   = activate[0];
    wire seconds  = (unit == `BWD_UNIT_SECONDS);
    wire run_now  = active & seconds & (tmo != `BWD_TMO_OFF);
    wire new_tmo  = wr_tmo & (i_io.wdata != `BWD_TMO_OFF);
    wire reload   = new_tmo | (i_refresh & run_now);
    wire expire   = run_now & tick & (remain == 8'h01) & ~reload;

    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (!is_open) begin
            next_rdata = 8'h00;
        end else if (!i_io.sel_data) begin
            next_rdata = index;
        end else if (index == `BWD_REG_LDN) begin
            next_rdata = ldn;
        end else if (!wdt_sel) begin
            next_rdata = 8'h00;
        end else if (index == `BWD_REG_ACT) begin
            next_rdata = activate;
        end else if (index == `BWD_REG_UNIT) begin
            next_rdata = unit;
        end else if (index == `BWD_REG_TMO) begin
            next_rdata = remain;
        end
    end

    bwd_tick #(
        .DIV (SEC_CYCLES)
    ) u_tick (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_clear   (reload | ~run_now),
        .o_tick    (tick)
    );

    // Unlock sequence: two back-to-back key writes to the index port
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_state <= BWD_LOCKED;
        end else if (i_ce && idx_wr && !is_open) begin
            case (cfg_state)
                BWD_LOCKED: cfg_state <= key_wr ? BWD_HALF : BWD_LOCKED;
                BWD_HALF:   cfg_state <= key_wr ? BWD_OPEN : BWD_LOCKED;
                default:    cfg_state <= BWD_LOCKED;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            index <= `BWD_RST_BYTE;
        end else if (i_ce && is_open && idx_wr) begin
            index <= i_io.wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ldn      <= `BWD_RST_BYTE;
            activate <= `BWD_RST_BYTE;
            unit     <= `BWD_RST_BYTE;
            tmo      <= `BWD_RST_BYTE;
        end else if (i_ce) begin
            if (wr_ldn) begin
                ldn <= i_io.wdata;
            end
            if (wr_act) begin
                activate <= i_io.wdata;
            end
            if (wr_unit) begin
                unit <= i_io.wdata;
            end
            if (wr_tmo) begin
                tmo <= i_io.wdata;
            end
        end
    end

    // Seconds left; reloads from the programmed or newly written value
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            remain <= `BWD_RST_BYTE;
        end else if (i_ce) begin
            if (new_tmo) begin
                remain <= i_io.wdata;
            end else if (wr_tmo) begin
                remain <= `BWD_TMO_OFF;
            end else if (reload) begin
                remain <= tmo;
            end else if (!run_now) begin
                remain <= tmo;
            end else if (tick && remain != 8'h00) begin
                remain <= remain - 8'h01;
            end
        end
    end

    // Reset pulse of fixed length on expiry
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_cnt <= 8'h00;
        end else if (i_ce) begin
            if (expire) begin
                rst_cnt <= 8'(RST_CYCLES);
            end else if (rst_cnt != 8'h00) begin
                rst_cnt <= rst_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata   <= 8'h00;
            o_running <= 1'b0;
            o_sys_rst <= 1'b0;
        end else if (i_ce) begin
            o_rdata   <= i_io.rd ? next_rdata : o_rdata;
            o_running <= run_now;
            o_sys_rst <= expire | (rst_cnt > 8'h01);
        end
    end

    property p_unlock;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_ce && cfg_state == BWD_HALF && key_wr) |=> is_open;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock failed");

    property p_locked_no_write;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!is_open && dat_wr) |=> $stable(ldn);
    endproperty
    a_locked_no_write: assert property (p_locked_no_write) else $error("locked write");

    property p_ldn_gate;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!wdt_sel && dat_wr && index == `BWD_REG_TMO) |=> $stable(tmo);
    endproperty
    a_ldn_gate: assert property (p_ldn_gate) else $error("bad routing");

    property p_unit;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_ce && unit != `BWD_UNIT_SECONDS) |=> !o_running;
    endproperty
    a_unit: assert property (p_unit) else $error("runs without seconds");

    property p_zero_off;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_ce && wr_tmo && i_io.wdata == `BWD_TMO_OFF) |=> ##1 !o_running;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero not off");

    property p_refresh;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_ce && i_refresh && run_now && !wr_tmo) |=> (remain == $past(tmo));
    endproperty
    a_refresh: assert property (p_refresh) else $error("no reload");

    property p_wr_reload;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_ce && new_tmo) |=> (remain == $past(i_io.wdata));
    endproperty
    a_wr_reload: assert property (p_wr_reload) else $error("write no reload");

    property p_expire;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_ce && expire) |=> o_sys_rst;
    endproperty
    a_expire: assert property (p_expire) else $error("no reset");
endmodule
`default_nettype wire

// ---- tb/bwd_host.sv ----
// Host software model driving the watchdog configuration port pair
`timescale 1ns/1ps
`default_nettype none
module bwd_host (
    input  wire logic        i_ref_clk,
    input  wire logic [7:0]  i_rdata,
    output bwd_pkg::bwd_io_t o_io,
    output logic             o_refresh
);
    import bwd_pkg::*;
    initial begin
        o_io = '0;
        o_refresh = 1'b0;
    end
    // Released data lines show the inverse of the last byte
    task automatic put(input logic sel, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_io = '{wr: 1'b1, rd: 1'b0, sel_data: sel, wdata: d};
        @(negedge i_ref_clk);
        o_io.wr = 1'b0;
        o_io.wdata = ~d;
    endtask
    task automatic set(input logic [7:0] a, input logic [7:0] d);
        put(1'b0, a);
        put(1'b1, d);
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        put(1'b0, a);
        o_io.rd = 1'b1;
        o_io.sel_data = 1'b1;
        @(negedge i_ref_clk);
        o_io.rd = 1'b0;
        d = i_rdata;
    endtask
    task automatic unlock();
        put(1'b0, 8'h87);
        put(1'b0, 8'h87);
    endtask
    task automatic setup();
        set(8'h07, 8'h08);
        set(8'h30, 8'h01);
        set(8'hF3, 8'h00);
    endtask
    task automatic kick();
        @(negedge i_ref_clk);
        o_refresh = 1'b1;
        @(negedge i_ref_clk);
        o_refresh = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/test_board_watchdog_timer.sv ----
// Self-checking testbench for the board watchdog timer
`timescale 1ns/1ps
`default_nettype none
module test_board_watchdog_timer;
    import bwd_pkg::*;
    localparam int SEC  = 20;
    localparam int RSTC = 4;
    logic       i_ref_clk = 1'b0;
    logic       i_arst_n  = 1'b0;
    logic       i_ce      = 1'b1;
    bwd_io_t    io;
    logic       refresh;
    logic [7:0] o_rdata;
    logic       o_running;
    logic       o_sys_rst;
    logic [7:0] rd;
    int         n_errors = 0;
    int         compares = 0;
    int         n;
    int         w;
    always #25 i_ref_clk = ~i_ref_clk;
    bwd_top #(.SEC_CYCLES(SEC), .RST_CYCLES(RSTC)) i_bwd_top (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
        .i_io(io), .i_refresh(refresh), .o_rdata(o_rdata),
        .o_running(o_running), .o_sys_rst(o_sys_rst));
    bwd_host i_bwd_host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata),
        .o_io(io), .o_refresh(refresh));
    task automatic chk(input string what, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, e);
        i_bwd_host.get(a, rd);
        chk(what, rd, e);
    endtask
    task automatic runchk(input logic e);
        repeat (2) @(negedge i_ref_clk);
        chk("running", {7'h00, o_running}, {7'h00, e});
    endtask
    // Cycles until system reset rises, then its width
    task automatic wait_rst(input int lim);
        n = 0;
        w = 0;
        while (o_sys_rst !== 1'b1 && n < lim) begin
            @(negedge i_ref_clk);
            n++;
        end
        while (o_sys_rst === 1'b1 && w < 50) begin
            @(negedge i_ref_clk);
            w++;
        end
    endtask
    task automatic win(input string what, input int lo, hi);
        chk(what, {7'h00, n >= lo && n <= hi}, 8'h01);
    endtask
    initial begin
        #(50 * 3000);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        chk("rst idle", {7'h00, o_sys_rst}, 8'h00);
        i_bwd_host.put(1'b0, 8'h87);
        i_bwd_host.put(1'b1, 8'h01);
        rdchk("locked", 8'h30, 8'h00);
        i_bwd_host.unlock();
        i_bwd_host.setup();
        i_bwd_host.set(8'h07, 8'h02);
        i_bwd_host.set(8'hF4, 8'h05);
        rdchk("tmo other dev", 8'hF4, 8'h00);
        i_bwd_host.set(8'h07, 8'h08);
        rdchk("tmo ignored", 8'hF4, 8'h00);
        rdchk("dev sel", 8'h07, 8'h08);
        rdchk("activate", 8'h30, 8'h01);
        rdchk("unit", 8'hF3, 8'h00);
        rdchk("unknown", 8'hF5, 8'h00);
        runchk(1'b0);
        i_bwd_host.set(8'hF4, 8'hFF);
        runchk(1'b1);
        i_bwd_host.set(8'hF3, 8'h01);
        runchk(1'b0);
        i_bwd_host.set(8'hF3, 8'h00);
        i_bwd_host.set(8'hF4, 8'h01);
        i_bwd_host.set(8'hF4, 8'h00);
        runchk(1'b0);
        wait_rst(60);
        chk("disabled", n[7:0], 8'h3C);
        i_bwd_host.set(8'hF4, 8'h02);
        wait_rst(300);
        win("expiry", 2 * SEC, 2 * SEC + 3);
        chk("rst width", w[7:0], RSTC[7:0]);
        i_bwd_host.set(8'hF4, 8'h03);
        repeat (30) @(negedge i_ref_clk);
        i_bwd_host.kick();
        wait_rst(300);
        win("refresh", 3 * SEC, 3 * SEC + 3);
        i_bwd_host.set(8'hF4, 8'h03);
        repeat (30) @(negedge i_ref_clk);
        i_bwd_host.set(8'hF4, 8'h04);
        wait_rst(300);
        win("reload", 4 * SEC, 4 * SEC + 3);
        // Clock enable low must freeze the seconds count
        i_bwd_host.set(8'hF4, 8'h05);
        i_ce = 1'b0;
        repeat (40) @(negedge i_ref_clk);
        i_ce = 1'b1;
        rdchk("frozen", 8'hF4, 8'h05);
        // Reset in mid-run clears registers and locks the ports again
        i_arst_n = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        chk("rst idle 2", {7'h00, o_sys_rst}, 8'h00);
        runchk(1'b0);
        rdchk("relocked", 8'hF4, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
